// *** core/mfc_pkg.sv ***
// shared constants and types for the motion and sample-queue configuration
package mfc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] MFC_ADDR_MOTION_CTL = 8'h27;
   localparam logic [7:0] MFC_ADDR_QUEUE_CTL  = 8'h28;
   localparam logic [7:0] MFC_ADDR_QUEUE_CNT  = 8'h29;

   localparam logic [7:0] MFC_RST_MOTION_CTL  = 8'h00;
   localparam logic [7:0] MFC_RST_QUEUE_CTL   = 8'h00;
   localparam logic [7:0] MFC_RST_QUEUE_CNT   = 8'h80;

   // bits with a function; the rest store nothing and read zero
   localparam logic [7:0] MFC_MASK_MOTION_CTL = 8'h3F;
   localparam logic [7:0] MFC_MASK_QUEUE_CTL  = 8'h0F;
   localparam logic [7:0] MFC_RDATA_NONE      = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int MFC_BIT_MOTION_ON  = 0;
   localparam int MFC_BIT_MOTION_REL = 1;
   localparam int MFC_BIT_STILL_ON   = 2;
   localparam int MFC_BIT_STILL_REL  = 3;
   localparam int MFC_BIT_SEQ_LO     = 4;
   localparam int MFC_BIT_SEQ_HI     = 5;
   localparam int MFC_BIT_MODE_LO    = 0;
   localparam int MFC_BIT_MODE_HI    = 1;
   localparam int MFC_BIT_STORE_TEMP = 2;
   localparam int MFC_BIT_COUNT_UPPER = 3;

   // ---------------------------------------------------------------
   // encodings and widths
   // ---------------------------------------------------------------
   localparam logic [1:0] MFC_SEQ_LOOP = 2'h3;
   localparam int MFC_AXES       = 3;
   localparam int MFC_SAMPLE_W   = 12;
   localparam int MFC_THRESH_W   = 11;
   localparam int MFC_STILL_W    = 16;
   localparam int MFC_WMARK_W    = 9;

   typedef enum logic [1:0] {
      MFC_QUEUE_OFF,
      MFC_QUEUE_OLDEST,
      MFC_QUEUE_STREAM,
      MFC_QUEUE_TRIGGER
   } mfc_queue_mode_t;

   // one set of signed axis readings, axis 0 = x
   typedef struct packed {
      logic [MFC_AXES-1:0][MFC_SAMPLE_W-1:0] axis;
   } mfc_sample_t;

   // sample-queue settings handed to the queue datapath
   typedef struct packed {
      mfc_queue_mode_t        mode;
      logic                   store_temp;
      logic [MFC_WMARK_W-1:0] watermark;
   } mfc_queue_cfg_t;
endpackage

// *** core/mfc_regs.sv ***
// motion detector and sample-queue configuration registers with detectors
`timescale 1ns/1ps
module mfc_regs
   import mfc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    soft_rst,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   input  wire logic                    status_read,
   input  wire logic                    sample_valid,
   input  wire mfc_sample_t             sample,
   input  wire logic [MFC_THRESH_W-1:0] motion_threshold,
   input  wire logic [MFC_THRESH_W-1:0] still_threshold,
   input  wire logic [MFC_STILL_W-1:0]  still_sample_count,
   output logic                         motion_flag,
   output logic                         still_flag,
   output logic                         watch_still,
   output logic                         auto_sleep_on,
   output logic      [1:0]              detector_armed,
   output mfc_queue_cfg_t               queue_cfg
);

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [7:0] motion_detect_control;
   logic [7:0] sample_queue_control;
   logic [7:0] sample_queue_count;

   wire hit_motion_ctl = reg_addr == MFC_ADDR_MOTION_CTL;
   wire hit_queue_ctl  = reg_addr == MFC_ADDR_QUEUE_CTL;
   wire hit_queue_cnt  = reg_addr == MFC_ADDR_QUEUE_CNT;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         motion_detect_control <= MFC_RST_MOTION_CTL;
         sample_queue_control  <= MFC_RST_QUEUE_CTL;
         sample_queue_count    <= MFC_RST_QUEUE_CNT;
      end else if (soft_rst) begin
         motion_detect_control <= MFC_RST_MOTION_CTL;
         sample_queue_control  <= MFC_RST_QUEUE_CTL;
         sample_queue_count    <= MFC_RST_QUEUE_CNT;
      end else if (reg_wr) begin
         if (hit_motion_ctl)
            motion_detect_control <= reg_wdata & MFC_MASK_MOTION_CTL;
         if (hit_queue_ctl)
            sample_queue_control <= reg_wdata & MFC_MASK_QUEUE_CTL;
         if (hit_queue_cnt)
            sample_queue_count <= reg_wdata;
      end
   end

   // unmapped addresses read as zero
   logic [7:0] next_rdata;
   assign next_rdata = hit_motion_ctl ? motion_detect_control :
                       hit_queue_ctl  ? sample_queue_control  :
                       hit_queue_cnt  ? sample_queue_count    :
                       MFC_RDATA_NONE;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         reg_rdata <= MFC_RDATA_NONE;
      else if (reg_rd)
         reg_rdata <= next_rdata;
   end

   // ---------------------------------------------------------------
   // queue configuration outputs
   // ---------------------------------------------------------------
   mfc_queue_cfg_t next_queue_cfg;
   assign next_queue_cfg.mode = mfc_queue_mode_t'(
      sample_queue_control[MFC_BIT_MODE_HI:MFC_BIT_MODE_LO]);
   assign next_queue_cfg.store_temp =
      sample_queue_control[MFC_BIT_STORE_TEMP];
   assign next_queue_cfg.watermark = {
      sample_queue_control[MFC_BIT_COUNT_UPPER],
      sample_queue_count};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         queue_cfg <= '0;
      else
         queue_cfg <= next_queue_cfg;
   end

   // ---------------------------------------------------------------
   // sequencing decode
   // ---------------------------------------------------------------
   wire motion_on  = motion_detect_control[MFC_BIT_MOTION_ON];
   wire still_on   = motion_detect_control[MFC_BIT_STILL_ON];
   wire [1:0] seq_field =
      motion_detect_control[MFC_BIT_SEQ_HI:MFC_BIT_SEQ_LO];
   // linked/loop need both enables, else independent mode
   wire seq_on  = seq_field[0] & motion_on & still_on;
   wire loop_on = seq_on & (seq_field == MFC_SEQ_LOOP);

   logic [1:0] armed;
   assign armed[0] = motion_on & (~seq_on | ~watch_still);
   assign armed[1] = still_on & (~seq_on | watch_still);

   logic [1:0] rel_sel;
   assign rel_sel[0] = motion_detect_control[MFC_BIT_MOTION_REL];
   assign rel_sel[1] = motion_detect_control[MFC_BIT_STILL_REL];

   logic [1:0][MFC_THRESH_W-1:0] thresh;
   assign thresh[0] = motion_threshold;
   assign thresh[1] = still_threshold;

   // ---------------------------------------------------------------
   // per-detector compare; detector 0 = activity, 1 = inactivity
   // ---------------------------------------------------------------
   logic [1:0]                evaluate;
   logic [1:0][MFC_AXES-1:0] above;
   logic [1:0][MFC_AXES-1:0] below;
   logic                      motion_evt;
   logic                      still_evt;

   genvar d;
   genvar a;
   generate
      for (d = 0; d < 2; d = d + 1) begin : g_det
         mfc_sample_t ref_q;
         logic        ref_ok;
         // a referenced detector spends its first armed sample on the
         // baseline, so its earliest event comes one sample later
         assign evaluate[d] = sample_valid & armed[d] &
                              (ref_ok | ~rel_sel[d]);
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               ref_q  <= '0;
               ref_ok <= 1'b0;
            end else if (soft_rst | ~armed[d] | ~rel_sel[d]) begin
               ref_ok <= 1'b0;
            end else if (sample_valid & ~ref_ok) begin
               ref_q  <= sample;
               ref_ok <= 1'b1;
            end else if (d == 0 ? motion_evt : still_evt) begin
               // re-baseline after every event
               ref_ok <= 1'b0;
            end
         end
         for (a = 0; a < MFC_AXES; a = a + 1) begin : g_axis
            logic signed [MFC_SAMPLE_W:0] diff;
            logic        [MFC_SAMPLE_W:0] mag;
            logic        [MFC_SAMPLE_W:0] thr_ext;
            assign diff = $signed({sample.axis[a][MFC_SAMPLE_W-1],
                                   sample.axis[a]}) -
                          (rel_sel[d] ? $signed({
                             ref_q.axis[a][MFC_SAMPLE_W-1],
                             ref_q.axis[a]}) :
                           $signed({(MFC_SAMPLE_W+1){1'b0}}));
            assign mag = diff[MFC_SAMPLE_W] ?
                         (MFC_SAMPLE_W+1)'(-diff) :
                         (MFC_SAMPLE_W+1)'(diff);
            assign thr_ext = {{(MFC_SAMPLE_W+1-MFC_THRESH_W){1'b0}},
                              thresh[d]};
            assign above[d][a] = mag > thr_ext;
            assign below[d][a] = mag < thr_ext;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // event generation
   // ---------------------------------------------------------------
   logic [MFC_STILL_W-1:0] still_cnt;
   logic [MFC_STILL_W-1:0] next_still_cnt;
   logic [MFC_STILL_W-1:0] still_goal;
   wire                    all_below = &below[1];

   // a programmed count of zero acts as one
   assign still_goal = (still_sample_count == '0) ?
                       MFC_STILL_W'(1) : still_sample_count;
   assign next_still_cnt = (still_cnt == '1) ? still_cnt :
                           still_cnt + MFC_STILL_W'(1);
   assign motion_evt = evaluate[0] & (|above[0]);
   assign still_evt  = evaluate[1] & all_below &
                       (next_still_cnt >= still_goal);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         still_cnt <= '0;
      else if (soft_rst | ~armed[1] | still_evt)
         still_cnt <= '0;
      else if (evaluate[1])
         still_cnt <= all_below ? next_still_cnt : '0;
   end

   // ---------------------------------------------------------------
   // phase and status flags
   // ---------------------------------------------------------------
   logic next_watch_still;
   logic next_motion_flag;
   logic next_still_flag;
   logic motion_clear;
   logic still_clear;

   // in loop mode the opposite event stands in for the host read
   assign motion_clear = loop_on ? still_evt : status_read;
   assign still_clear  = loop_on ? motion_evt : status_read;

   // set wins over a clear arriving in the same cycle
   assign next_motion_flag = motion_evt | (motion_flag & ~motion_clear);
   assign next_still_flag  = still_evt | (still_flag & ~still_clear);

   assign next_watch_still = ~seq_on   ? 1'b0 :
                             motion_evt ? 1'b1 :
                             still_evt  ? 1'b0 :
                             watch_still;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         watch_still    <= 1'b0;
         motion_flag    <= 1'b0;
         still_flag     <= 1'b0;
         auto_sleep_on  <= 1'b0;
         detector_armed <= 2'h0;
      end else if (soft_rst) begin
         watch_still    <= 1'b0;
         motion_flag    <= 1'b0;
         still_flag     <= 1'b0;
         auto_sleep_on  <= 1'b0;
         detector_armed <= 2'h0;
      end else begin
         watch_still    <= next_watch_still;
         motion_flag    <= next_motion_flag;
         still_flag     <= next_still_flag;
         auto_sleep_on  <= seq_on;
         detector_armed <= armed;
      end
   end

endmodule

// *** testbench/mfc_host.sv ***
// host side model: register transfers and status acknowledge
`timescale 1ns/1ps
module mfc_host (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr = 1'b0,
   output logic            reg_rd = 1'b0,
   output logic      [7:0] reg_addr = 8'h00,
   output logic      [7:0] reg_wdata = 8'h00,
   output logic            status_read = 1'b0
);
   // released address and data lines carry the inverse so a stale value never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, d,
                       output logic [7:0] q);
      @(posedge clk) #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(posedge clk) #1;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
      q = reg_rdata;
   endtask
   // outside loop sequencing the flags wait for this read
   task automatic ack();
      @(posedge clk) #1;
      status_read = 1'b1;
      @(posedge clk) #1;
      status_read = 1'b0;
   endtask
endmodule

// *** testbench/mfc_regs_chk.sv ***
// port checks for the motion and sample-queue configuration block
`timescale 1ns/1ps
module mfc_regs_chk
   import mfc_pkg::*;
(
   input wire logic           clk,
   input wire logic           sys_rst,
   input wire logic           soft_rst,
   input wire logic           reg_wr,
   input wire logic [7:0]     reg_addr,
   input wire logic [7:0]     reg_wdata,
   input wire logic           status_read,
   input wire logic           sample_valid,
   input wire logic           motion_flag,
   input wire logic           still_flag,
   input wire logic           watch_still,
   input wire logic           auto_sleep_on,
   input wire logic [1:0]     detector_armed,
   input wire mfc_queue_cfg_t queue_cfg
);
   logic [7:0] sh;
   wire        lk = sh[0] && sh[2] && sh[4];
   wire        lp = lk && sh[5];
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // shadow of the motion control bits; outputs lag it by a cycle
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         sh <= 8'h00;
      else if (soft_rst || (reg_wr && reg_addr == MFC_ADDR_MOTION_CTL))
         sh <= soft_rst ? 8'h00 : reg_wdata & MFC_MASK_MOTION_CTL;
   AST_WMARK: assert property (reg_wr && !soft_rst &&
      reg_addr == MFC_ADDR_QUEUE_CNT ##1 !soft_rst
      |-> ##1 queue_cfg.watermark[7:0] == $past(reg_wdata, 2))
      else $error("watermark byte wrong");
   AST_QCTL: assert property (reg_wr && !soft_rst &&
      reg_addr == MFC_ADDR_QUEUE_CTL ##1 !soft_rst
      |-> ##1 {queue_cfg.watermark[8], queue_cfg.store_temp, queue_cfg.mode}
      == $past(reg_wdata[3:0], 2)) else $error("queue fields wrong");
   AST_SLEEP: assert property ($stable(lk) |-> auto_sleep_on == lk)
      else $error("auto sleep wrong");
   AST_DEFARM: assert property (!lk && $stable(sh)
      |-> detector_armed == {sh[2], sh[0]}) else $error("arming wrong");
   AST_ONEARM: assert property (lk && $stable(sh)
      && $stable(watch_still)
      |-> detector_armed == {watch_still, !watch_still})
      else $error("sequenced arming wrong");
   AST_LINK: assert property (lk && $rose(motion_flag) |-> watch_still)
      else $error("no swap to inactivity");
   AST_ACK: assert property (!lp && status_read && !sample_valid
      && !soft_rst |=> !motion_flag && !still_flag)
      else $error("status read kept flags");
   AST_HOLD: assert property (motion_flag && !status_read && !lp
      && !soft_rst |=> motion_flag) else $error("activity flag dropped");
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the motion and sample-queue registers
`timescale 1ns/1ps
module testbench;
   import mfc_pkg::*;
   logic           clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0;
   logic           sample_valid = 1'b0;
   mfc_sample_t    sample = '0;
   logic [10:0]    motion_threshold = 11'h00A, still_threshold = 11'h00A;
   logic [15:0]    still_sample_count = 16'h0002;
   logic           reg_wr, reg_rd, status_read, motion_flag, still_flag;
   logic           watch_still, auto_sleep_on;
   logic [7:0]     reg_addr, reg_wdata, reg_rdata, q;
   logic [1:0]     detector_armed;
   mfc_queue_cfg_t queue_cfg;
   int             n_mismatch = 0, cmp_count = 0;
   mfc_regs DUT (.*);
   mfc_host host (.*);
   always #12.5 clk = ~clk;
   // ----------
   // helpers
   // ----------
   task automatic chk(input logic [11:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, exp);
      host.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic wr(input logic [7:0] a, d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic smp(input logic [11:0] x);
      @(posedge clk) #1;
      {sample_valid, sample.axis[0]} = {1'b1, x};
      @(posedge clk) #1;
      {sample_valid, sample.axis[0]} = {1'b0, ~x};
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // whole run is about a hundred cycles
   initial begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      rchk(MFC_ADDR_MOTION_CTL, 8'h00);
      rchk(MFC_ADDR_QUEUE_CTL, 8'h00);
      rchk(MFC_ADDR_QUEUE_CNT, 8'h80);
      rchk(8'h2A, 8'h00);
      chk(queue_cfg.watermark, 12'h080);
      wr(MFC_ADDR_MOTION_CTL, 8'hFF);
      rchk(MFC_ADDR_MOTION_CTL, 8'h3F);
      wr(MFC_ADDR_QUEUE_CNT, 8'hFF);
      for (int m = 0; m < 4; m++) begin
         wr(MFC_ADDR_QUEUE_CTL, {5'h1F, m[0], m[1:0]});
         rchk(MFC_ADDR_QUEUE_CTL, {5'h01, m[0], m[1:0]});
         chk(queue_cfg, {m[1:0], m[0], 9'h1FF});
      end
      $display("register test done");
      @(posedge clk) #1 soft_rst = 1'b1;
      @(posedge clk) #1 soft_rst = 1'b0;
      rchk(MFC_ADDR_QUEUE_CNT, 8'h80);
      rchk(MFC_ADDR_MOTION_CTL, 8'h00);
      $display("soft reset test done");
      wr(MFC_ADDR_MOTION_CTL, 8'h05);
      @(posedge clk) #1;
      chk({auto_sleep_on, detector_armed}, 12'h3);
      smp(12'hFEC);
      chk(motion_flag, 1'b1);
      smp(12'h000);
      chk(still_flag, 1'b0);
      smp(12'h000);
      chk({motion_flag, still_flag}, 2'h3);
      host.ack();
      chk({motion_flag, still_flag}, 2'h0);
      // sequencing code 10 must also fall back to independent mode
      wr(MFC_ADDR_MOTION_CTL, 8'h25);
      @(posedge clk) #1;
      chk({auto_sleep_on, detector_armed}, 12'h3);
      $display("independent test done");
      wr(MFC_ADDR_MOTION_CTL, 8'h15);
      @(posedge clk) #1;
      chk({auto_sleep_on, detector_armed}, 12'h5);
      smp(12'h014);
      chk({motion_flag, watch_still}, 2'h3);
      smp(12'h000);
      smp(12'h000);
      chk({motion_flag, still_flag, watch_still}, 3'h6);
      host.ack();
      $display("linked test done");
      wr(MFC_ADDR_MOTION_CTL, 8'h35);
      smp(12'h014);
      host.ack();
      chk(motion_flag, 1'b1);
      smp(12'h000);
      smp(12'h000);
      chk({motion_flag, still_flag}, 2'h1);
      wr(MFC_ADDR_MOTION_CTL, 8'h31);
      @(posedge clk) #1 chk({auto_sleep_on, detector_armed}, 12'h1);
      $display("loop test done");
      host.ack();
      wr(MFC_ADDR_MOTION_CTL, 8'h00);
      wr(MFC_ADDR_MOTION_CTL, 8'h03);
      smp(12'h064);
      smp(12'h069);
      chk(motion_flag, 1'b0);
      smp(12'h078);
      chk(motion_flag, 1'b1);
      // absolute values stay above the still threshold, offsets do not
      wr(MFC_ADDR_MOTION_CTL, 8'h0C);
      smp(12'h064);
      smp(12'h069);
      chk(still_flag, 1'b0);
      smp(12'h067);
      chk(still_flag, 1'b1);
      $display("referenced test done");
      close_out();
   end
endmodule
bind mfc_regs mfc_regs_chk u_chk (.*);
